// file: psf_status_page.sv
// Purpose: lowest register page with identity, live status, sticky flags and masks
// Assumes: the serial port front end delivers byte reads and writes on clk
// Notes: status inputs come from other domains and are filtered here
`timescale 1ns/10ps
module psf_status_page #(
  parameter logic [15:0] PART_NUMBER = 16'h1234, // arbitrary identity value
  parameter logic [7:0] GRADE_CODE = 8'h00, // arbitrary identity value
  parameter logic [7:0] REVISION_CODE = 8'h00, // arbitrary identity value
  parameter logic [7:0] TEMP_GRADE_CODE = 8'h00, // arbitrary identity value
  parameter logic [7:0] PACKAGE_CODE = 8'h00, // arbitrary identity value
  parameter logic [6:0] SLAVE_ADDR_RESET = 7'h68
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [psf_pkg::ADDR_W-1:0] regAddr,
  input wire logic [psf_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [psf_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,
  output logic [7:0] activePage,
  output logic [6:0] serialSlaveAddr,
  output logic [1:0] lockLossHoldoverConfig,
  output logic [23:0] configToolVersion,
  input wire logic deviceCalibrating,
  input wire logic referencePinSignalLoss,
  input wire logic referenceSignalLoss,
  input wire logic referenceLockProblem,
  input wire logic busTimeout,
  input wire logic [3:0] inputSignalLoss,
  input wire logic [3:0] inputOutOfFrequency,
  input wire logic [1:0] pllUnlocked,
  input wire logic [1:0] pllHoldover,
  input wire logic [1:0] pllCalibrating,
  output logic intrReq
);
  import psf_pkg::*;

  logic [LIVE_W-1:0] liveRaw;
  logic [LIVE_W-1:0] sync1_q, sync2_q, sync3_q, live_q, live_d;
  logic [7:0] page_q, page_d;
  logic [7:0] tool0_q, tool0_d, tool1_q, tool1_d, tool2_q, tool2_d;
  logic [6:0] slave_q, slave_d;
  logic [1:0] holdCfg_q, holdCfg_d;
  logic [7:0] faultMask_q, faultMask_d, inMask_q, inMask_d;
  logic [7:0] pllMask_q, pllMask_d, calMask_q, calMask_d;
  logic [7:0] faultFlag_q, faultFlag_d, inFlag_q, inFlag_d;
  logic [7:0] pllFlag_q, pllFlag_d, calFlag_q, calFlag_d;
  logic [7:0] faultLive, inLive, pllLive, calLive;
  logic [7:0] rdData_q, rdData_d;
  logic rdValid_q, rdValid_d;
  logic intr_q, intr_d;
  logic onPage0, wrPage;

  // write strobe for one offset of page zero
  function automatic logic hit(input logic en, input logic p0, input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = en & p0 & (a == ofs);
  endfunction

  // sticky update: a live bit set wins over a write-zero clear
  function automatic logic [7:0] sticky(input logic [7:0] flag, input logic [7:0] live,
                                        input logic clr, input logic [7:0] wd,
                                        input logic [7:0] bits);
    logic [7:0] keep;
    keep = clr ? (flag & wd) : flag;
    sticky = (keep | live) & bits;
  endfunction

  // gather the asynchronous status inputs into one vector
  assign liveRaw = {pllCalibrating, pllHoldover, pllUnlocked, inputOutOfFrequency,
                    inputSignalLoss, busTimeout, referenceLockProblem, referenceSignalLoss,
                    referencePinSignalLoss, deviceCalibrating};

  // filtered value moves only where second and third stages agree
  always_comb begin
    live_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (live_q & (sync2_q ^ sync3_q));
  end

  // three-stage synchroniser and filtered status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      live_q <= '0;
    end else begin
      sync1_q <= liveRaw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      live_q <= live_d;
    end
  end

  // live status bytes, no latching on these
  assign faultLive = {2'b00, live_q[LV_TIMEOUT], 1'b0, live_q[LV_REF_LOCK],
                      live_q[LV_REF], live_q[LV_REF_PIN], live_q[LV_CAL]};
  assign inLive = {live_q[LV_OOF +: 4], live_q[LV_LOS +: 4]};
  assign pllLive = {2'b00, live_q[LV_HOLD +: 2], 2'b00, live_q[LV_UNLOCK +: 2]};
  assign calLive = {2'b00, live_q[LV_PLL_CAL +: 2], 4'h0};

  // page select answers at offset 01 on every page
  assign wrPage = regWrEn & (regAddr == OFS_PAGE);
  assign onPage0 = (page_q == PAGE_ZERO);

  // next values of the software-written registers
  always_comb begin
    page_d = wrPage ? regWrData : page_q;
    tool0_d = hit(regWrEn, onPage0, regAddr, OFS_TOOL0) ? regWrData : tool0_q;
    tool1_d = hit(regWrEn, onPage0, regAddr, OFS_TOOL1) ? regWrData : tool1_q;
    tool2_d = hit(regWrEn, onPage0, regAddr, OFS_TOOL2) ? regWrData : tool2_q;
    // slave address holds bits 6:0 only
    slave_d = hit(regWrEn, onPage0, regAddr, OFS_SLAVE_ADDR) ? regWrData[6:0] : slave_q;
    holdCfg_d = hit(regWrEn, onPage0, regAddr, OFS_HOLD_CFG) ? regWrData[1:0] : holdCfg_q;
    faultMask_d = hit(regWrEn, onPage0, regAddr, OFS_FAULT_MASK) ?
                  (regWrData & BITS_FAULT_MASK) : faultMask_q;
    inMask_d = hit(regWrEn, onPage0, regAddr, OFS_INPUT_MASK) ? regWrData : inMask_q;
    pllMask_d = hit(regWrEn, onPage0, regAddr, OFS_PLL_MASK) ?
                (regWrData & BITS_PLL) : pllMask_q;
    calMask_d = hit(regWrEn, onPage0, regAddr, OFS_CAL_MASK) ?
                (regWrData & BITS_CAL) : calMask_q;
  end

  // control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_q <= RST_PAGE;
      tool0_q <= RST_ZERO;
      tool1_q <= RST_ZERO;
      tool2_q <= RST_ZERO;
      slave_q <= SLAVE_ADDR_RESET;
      holdCfg_q <= 2'b00;
      faultMask_q <= RST_FAULT_MASK;
      inMask_q <= RST_MASK;
      pllMask_q <= RST_MASK;
      calMask_q <= RST_MASK;
    end else begin
      page_q <= page_d;
      tool0_q <= tool0_d;
      tool1_q <= tool1_d;
      tool2_q <= tool2_d;
      slave_q <= slave_d;
      holdCfg_q <= holdCfg_d;
      faultMask_q <= faultMask_d;
      inMask_q <= inMask_d;
      pllMask_q <= pllMask_d;
      calMask_q <= calMask_d;
    end
  end

  // sticky flags: set by live bits, cleared by writing zero
  always_comb begin
    faultFlag_d = sticky(faultFlag_q, faultLive,
                         hit(regWrEn, onPage0, regAddr, OFS_FAULT_FLAG), regWrData, BITS_FAULT);
    inFlag_d = sticky(inFlag_q, inLive,
                      hit(regWrEn, onPage0, regAddr, OFS_INPUT_FLAG), regWrData, BITS_INPUT);
    pllFlag_d = sticky(pllFlag_q, pllLive,
                       hit(regWrEn, onPage0, regAddr, OFS_PLL_FLAG), regWrData, BITS_PLL);
    calFlag_d = sticky(calFlag_q, calLive,
                       hit(regWrEn, onPage0, regAddr, OFS_CAL_FLAG), regWrData, BITS_CAL);
  end

  // flag registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultFlag_q <= RST_ZERO;
      inFlag_q <= RST_ZERO;
      pllFlag_q <= RST_ZERO;
      calFlag_q <= RST_ZERO;
    end else begin
      faultFlag_q <= faultFlag_d;
      inFlag_q <= inFlag_d;
      pllFlag_q <= pllFlag_d;
      calFlag_q <= calFlag_d;
    end
  end

  // interrupt from unmasked latched flags
  always_comb begin
    intr_d = |((faultFlag_q & ~faultMask_q) | (inFlag_q & ~inMask_q) |
               (pllFlag_q & ~pllMask_q) | (calFlag_q & ~calMask_q));
  end

  // read data mux; other pages show only the page select
  always_comb begin
    rdData_d = rdData_q;
    rdValid_d = regRdEn;
    if (regRdEn) begin
      rdData_d = RST_ZERO;
      if (regAddr == OFS_PAGE) begin
        rdData_d = page_q;
      end else if (onPage0) begin
        case (regAddr)
          OFS_PART_LO: rdData_d = PART_NUMBER[7:0];
          OFS_PART_HI: rdData_d = PART_NUMBER[15:8];
          OFS_GRADE: rdData_d = GRADE_CODE;
          OFS_REVISION: rdData_d = REVISION_CODE;
          OFS_TOOL0: rdData_d = tool0_q;
          OFS_TOOL1: rdData_d = tool1_q;
          OFS_TOOL2: rdData_d = tool2_q;
          OFS_TEMP_GRADE: rdData_d = TEMP_GRADE_CODE;
          OFS_PACKAGE: rdData_d = PACKAGE_CODE;
          OFS_SLAVE_ADDR: rdData_d = {1'b0, slave_q};
          OFS_FAULT_LIVE: rdData_d = faultLive;
          OFS_INPUT_LIVE: rdData_d = inLive;
          OFS_PLL_LIVE: rdData_d = pllLive;
          OFS_CAL_LIVE: rdData_d = calLive;
          OFS_FAULT_FLAG: rdData_d = faultFlag_q;
          OFS_INPUT_FLAG: rdData_d = inFlag_q;
          OFS_PLL_FLAG: rdData_d = pllFlag_q;
          OFS_CAL_FLAG: rdData_d = calFlag_q;
          OFS_HOLD_CFG: rdData_d = {6'h00, holdCfg_q};
          OFS_FAULT_MASK: rdData_d = faultMask_q;
          OFS_INPUT_MASK: rdData_d = inMask_q;
          OFS_PLL_MASK: rdData_d = pllMask_q;
          OFS_CAL_MASK: rdData_d = calMask_q;
          default: rdData_d = RST_ZERO;
        endcase
      end
    end
  end

  // read answer and interrupt registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_q <= RST_ZERO;
      rdValid_q <= 1'b0;
      intr_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      intr_q <= intr_d;
    end
  end

  // outputs
  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign activePage = page_q;
  assign serialSlaveAddr = slave_q;
  assign lockLossHoldoverConfig = holdCfg_q;
  assign configToolVersion = {tool2_q, tool1_q, tool0_q};
  assign intrReq = intr_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence pageWrite;
    regWrEn && regAddr == OFS_PAGE;
  endsequence

  sequence pageRead;
    regRdEn && regAddr == OFS_PAGE;
  endsequence

  sequence heldFour(sig);
    sig [*4];
  endsequence

  sequence quietFour(sig);
    !sig [*4];
  endsequence

  AST_PAGE_WRITE: assert property (pageWrite |=> page_q == $past(regWrData))
    else $error("page select did not take written value");

  AST_PAGE_READ: assert property (pageRead |=> regRdValid && regRdData == $past(page_q))
    else $error("page select read mismatch");

  AST_PART_HI: assert property (regRdEn && onPage0 && regAddr == OFS_PART_HI
                                |=> regRdData == PART_NUMBER[15:8])
    else $error("part number high byte wrong");

  AST_SLAVE_TOP: assert property (regRdEn && onPage0 && regAddr == OFS_SLAVE_ADDR
                                  |=> regRdData[7] == 1'b0 && regRdData[6:0] == $past(slave_q))
    else $error("slave address read wrong");

  AST_MASK_RESET: assert property (@(posedge clk) disable iff (1'b0)
                                   sys_rst |=> faultMask_q[7:6] == 2'b11)
    else $error("reserved mask bits not set after reset");

  AST_LOS_LIVE: assert property (quietFour(inputSignalLoss[0]) |=> !inLive[0])
    else $error("live loss bit latched");

  AST_STICKY_SET: assert property (live_q[LV_TIMEOUT] |=> faultFlag_q[5])
    else $error("fault flag did not set from live bit");

  AST_STICKY_HOLD: assert property (inFlag_q[0] && !(regWrEn && onPage0 && regAddr ==
                                    OFS_INPUT_FLAG) |=> inFlag_q[0])
    else $error("input flag dropped without clear");

  AST_CLEAR: assert property (regWrEn && onPage0 && regAddr == OFS_PLL_FLAG &&
                              !regWrData[0] && !pllLive[0] |=> !pllFlag_q[0])
    else $error("pll flag not cleared by zero write");

  AST_CAL_FLAG: assert property (live_q[LV_PLL_CAL + 1] ##1
                                 !(regWrEn && onPage0 && regAddr == OFS_CAL_FLAG)
                                 |-> calFlag_q[5] [*2])
    else $error("calibration flag not held");

  AST_INTR: assert property (faultFlag_q[0] && !faultMask_q[0] |=> intrReq)
    else $error("unmasked flag gave no interrupt");

  AST_MASKED: assert property ((faultFlag_q & ~faultMask_q) == 8'h00 &&
                               inFlag_q == 8'h00 && pllFlag_q == 8'h00 && calFlag_q == 8'h00
                               |=> !intrReq)
    else $error("masked flag raised interrupt");

  AST_FILTER: assert property ($rose(liveRaw[LV_CAL]) ##1 liveRaw[LV_CAL] [*4]
                               |-> faultLive[0])
    else $error("calibration status did not follow input");

  AST_PAGE_HOLD: assert property (!(regWrEn && regAddr == OFS_PAGE)
                                  |=> page_q == $past(page_q))
    else $error("page select changed without a write");

  AST_OFF_PAGE: assert property (regRdEn && !onPage0 && regAddr != OFS_PAGE
                                 |=> regRdData == RST_ZERO)
    else $error("off-page read not zero");

  AST_PART_LO: assert property (regRdEn && onPage0 && regAddr == OFS_PART_LO
                                |=> regRdData == PART_NUMBER[7:0])
    else $error("part number low byte wrong");

  AST_GRADE: assert property (regRdEn && onPage0 && regAddr == OFS_GRADE
                              |=> regRdData == GRADE_CODE)
    else $error("grade code wrong");

  AST_REVISION: assert property (regRdEn && onPage0 && regAddr == OFS_REVISION
                                 |=> regRdData == REVISION_CODE)
    else $error("revision code wrong");

  AST_SLAVE_WRITE: assert property (regWrEn && onPage0 && regAddr == OFS_SLAVE_ADDR
                                    |=> serialSlaveAddr == $past(regWrData[6:0]))
    else $error("slave address write lost");

  AST_REF_PIN_LIVE: assert property (heldFour(referencePinSignalLoss)
                                     |=> faultLive[1])
    else $error("reference pin loss not shown");

  AST_REF_LOCK_LIVE: assert property (heldFour(referenceLockProblem)
                                      |=> faultLive[3])
    else $error("reference lock problem not shown");

  AST_TIMEOUT_LIVE: assert property (heldFour(busTimeout)
                                     |=> faultLive[5])
    else $error("bus timeout not shown");

  AST_OOF_LIVE: assert property (heldFour(inputOutOfFrequency[3])
                                 |=> inLive[7])
    else $error("input 3 off-frequency not shown");

  AST_UNLOCK_LIVE: assert property (heldFour(pllUnlocked[1])
                                    |=> pllLive[1])
    else $error("pll b unlock not shown");

  AST_PLL_CAL_LIVE: assert property (heldFour(pllCalibrating[0])
                                     |=> calLive[4])
    else $error("pll a calibration not shown");

  AST_FAULT_CLEAR: assert property (regWrEn && onPage0 && regAddr == OFS_FAULT_FLAG
                                    && !regWrData[5] && !faultLive[5] |=> !faultFlag_q[5])
    else $error("fault flag not cleared by zero write");

  AST_HOLD_SET: assert property (pllLive[5]
                                 |=> pllFlag_q[5])
    else $error("holdover flag did not set");

  AST_MASK_WRITE: assert property (regWrEn && onPage0 && regAddr == OFS_FAULT_MASK
                                   |=> faultMask_q == ($past(regWrData) & BITS_FAULT_MASK))
    else $error("fault mask write lost");

  AST_INPUT_INTR: assert property (inFlag_q[7] && !inMask_q[7]
                                   |=> intrReq)
    else $error("unmasked input flag gave no interrupt");
endmodule

// file: psf_pkg.sv
// Purpose: constants for the status and flag register page
// Assumes: byte-wide register port, page held inside the block
// Notes: offsets are byte offsets within the selected page
package psf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LIVE_W = 19;
  // register offsets within a page
  localparam logic [7:0] OFS_PAGE = 8'h01;
  localparam logic [7:0] OFS_PART_LO = 8'h02;
  localparam logic [7:0] OFS_PART_HI = 8'h03;
  localparam logic [7:0] OFS_GRADE = 8'h04;
  localparam logic [7:0] OFS_REVISION = 8'h05;
  localparam logic [7:0] OFS_TOOL0 = 8'h06;
  localparam logic [7:0] OFS_TOOL1 = 8'h07;
  localparam logic [7:0] OFS_TOOL2 = 8'h08;
  localparam logic [7:0] OFS_TEMP_GRADE = 8'h09;
  localparam logic [7:0] OFS_PACKAGE = 8'h0A;
  localparam logic [7:0] OFS_SLAVE_ADDR = 8'h0B;
  localparam logic [7:0] OFS_FAULT_LIVE = 8'h0C;
  localparam logic [7:0] OFS_INPUT_LIVE = 8'h0D;
  localparam logic [7:0] OFS_PLL_LIVE = 8'h0E;
  localparam logic [7:0] OFS_CAL_LIVE = 8'h0F;
  localparam logic [7:0] OFS_FAULT_FLAG = 8'h11;
  localparam logic [7:0] OFS_INPUT_FLAG = 8'h12;
  localparam logic [7:0] OFS_PLL_FLAG = 8'h13;
  localparam logic [7:0] OFS_CAL_FLAG = 8'h14;
  localparam logic [7:0] OFS_HOLD_CFG = 8'h16;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h17;
  localparam logic [7:0] OFS_INPUT_MASK = 8'h18;
  localparam logic [7:0] OFS_PLL_MASK = 8'h19;
  localparam logic [7:0] OFS_CAL_MASK = 8'h1A;
  // implemented bits of each byte
  localparam logic [7:0] BITS_FAULT = 8'h2F;
  localparam logic [7:0] BITS_INPUT = 8'hFF;
  localparam logic [7:0] BITS_PLL = 8'h33;
  localparam logic [7:0] BITS_CAL = 8'h30;
  localparam logic [7:0] BITS_FAULT_MASK = 8'hEF;
  localparam logic [7:0] BITS_SLAVE_ADDR = 8'h7F;
  localparam logic [7:0] BITS_HOLD_CFG = 8'h03;
  // reset values
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_FAULT_MASK = 8'hC0;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RESERVED_MASK_BITS = 8'hC0;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  // field positions in the live status vector
  localparam int LV_CAL = 0;
  localparam int LV_REF_PIN = 1;
  localparam int LV_REF = 2;
  localparam int LV_REF_LOCK = 3;
  localparam int LV_TIMEOUT = 4;
  localparam int LV_LOS = 5;
  localparam int LV_OOF = 9;
  localparam int LV_UNLOCK = 13;
  localparam int LV_HOLD = 15;
  localparam int LV_PLL_CAL = 17;
endpackage

// file: psf_host_model.sv
// Purpose: host controller model on the byte-wide register port
// Assumes: one strobe per access, launched just after a rising edge
// Notes: idle address and data lines toggle so stale values never pass
`timescale 1ns/10ps
module psf_host_model (
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic clk,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid
);
  import psf_pkg::*;
  // idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  // single write, strobe seen at exactly one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= (a == OFS_FAULT_MASK) ? (d | RESERVED_MASK_BITS) : d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
    // one more edge so the written value is visible on return
    @(posedge clk);
  endtask
  // single read, answer taken at the edge where valid is high
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    d = 8'hXX;
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      if (regRdValid === 1'b1) begin
        d = regRdData;
        break;
      end
    end
  endtask
endmodule

// file: psf_status_page_tb_top.sv
// Purpose: self-checking bench for the status and flag register page
// Assumes: status levels held long enough to pass the input filter
// Notes: expected values come from a bench model of live, sticky and mask bytes
`timescale 1ns/10ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin nFail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end
module psf_status_page_tb_top;
  import psf_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] regAddr, regWrData, regRdData, activePage;
  logic regWrEn, regRdEn, regRdValid, intrReq;
  logic [6:0] serialSlaveAddr;
  logic [1:0] lockLossHoldoverConfig;
  logic [23:0] configToolVersion;
  logic [18:0] stat = '0;
  logic [7:0] flagM [4];
  logic [7:0] maskM [4];
  logic [7:0] d, r, lv;
  logic [7:0] idOfs [6] = '{OFS_PART_LO, OFS_PART_HI, OFS_GRADE, OFS_REVISION,
                            OFS_TEMP_GRADE, OFS_PACKAGE};
  logic [7:0] idVal [6] = '{8'h68, 8'h24, 8'h03, 8'h01, 8'h02, 8'h05};
  logic [7:0] mBits [4] = '{BITS_FAULT_MASK, BITS_INPUT, BITS_PLL, BITS_CAL};
  logic expIntr;
  int nFail = 0;
  int checked = 0;
  int it, k;
  // free-running clock, 25 ns period
  always #12.5 clk = ~clk;
  // identity values here are arbitrary
  psf_status_page #(.PART_NUMBER(16'h2468), .GRADE_CODE(8'h03), .REVISION_CODE(8'h01),
    .TEMP_GRADE_CODE(8'h02), .PACKAGE_CODE(8'h05))
  psf_status_page_inst (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .activePage(activePage), .serialSlaveAddr(serialSlaveAddr),
    .lockLossHoldoverConfig(lockLossHoldoverConfig), .configToolVersion(configToolVersion),
    .deviceCalibrating(stat[0]), .referencePinSignalLoss(stat[1]),
    .referenceSignalLoss(stat[2]), .referenceLockProblem(stat[3]), .busTimeout(stat[4]),
    .inputSignalLoss(stat[8:5]), .inputOutOfFrequency(stat[12:9]),
    .pllUnlocked(stat[14:13]), .pllHoldover(stat[16:15]), .pllCalibrating(stat[18:17]),
    .intrReq(intrReq));
  psf_host_model psf_host_model_inst (.clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid));
  // expected live byte from the raw status levels
  function automatic logic [7:0] liveReg(int n, logic [18:0] s);
    case (n)
      0: return {2'b00, s[4], 1'b0, s[3], s[2], s[1], s[0]};
      1: return {s[12:9], s[8:5]};
      2: return {2'b00, s[16:15], 2'b00, s[14:13]};
      default: return {2'b00, s[18:17], 4'b0000};
    endcase
  endfunction
  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far beyond the expected run length
  initial begin
    #(25 * 40000);
    nFail++;
    finish_test;
  end
  // main sequence
  initial begin
    void'($urandom(62943));
    repeat (4) @(posedge clk);
    sysRst <= 1'b0;
    // reset values
    psf_host_model_inst.rd(OFS_PAGE, d);
    `CHK(d, RST_PAGE)
    psf_host_model_inst.rd(OFS_SLAVE_ADDR, d);
    `CHK(d, 8'h68)
    psf_host_model_inst.rd(OFS_FAULT_MASK, d);
    `CHK(d, RST_FAULT_MASK)
    `CHK(intrReq, 1'b0)
    // identity bytes ignore writes
    for (k = 0; k < 6; k++) begin
      psf_host_model_inst.wr(idOfs[k], ~idVal[k]);
      psf_host_model_inst.rd(idOfs[k], d);
      `CHK(d, idVal[k])
    end
    // page select mirrored on a foreign page, other offsets unmapped there
    psf_host_model_inst.wr(OFS_PAGE, 8'hA5);
    psf_host_model_inst.rd(OFS_PAGE, d);
    `CHK(d, 8'hA5)
    `CHK(activePage, 8'hA5)
    psf_host_model_inst.rd(OFS_PART_LO, d);
    `CHK(d, 8'h00)
    psf_host_model_inst.wr(OFS_PAGE, PAGE_ZERO);
    psf_host_model_inst.rd(8'h10, d);
    `CHK(d, 8'h00)
    // writable configuration bytes
    psf_host_model_inst.wr(OFS_SLAVE_ADDR, 8'hFF);
    psf_host_model_inst.rd(OFS_SLAVE_ADDR, d);
    `CHK(d, BITS_SLAVE_ADDR)
    `CHK(serialSlaveAddr, 7'h7F)
    psf_host_model_inst.wr(OFS_HOLD_CFG, 8'hFF);
    `CHK(lockLossHoldoverConfig, 2'b11)
    psf_host_model_inst.wr(OFS_TOOL0, 8'h5A);
    psf_host_model_inst.wr(OFS_TOOL1, 8'hC3);
    psf_host_model_inst.wr(OFS_TOOL2, 8'h96);
    `CHK(configToolVersion, 24'h96C35A)
    // random status, masks and flag clears against the bench model
    for (k = 0; k < 4; k++) begin
      flagM[k] = 8'h00;
    end
    for (it = 0; it < 24; it++) begin
      r = 8'($urandom());
      stat <= 19'($urandom());
      repeat (8) @(posedge clk);
      for (k = 0; k < 4; k++) begin
        flagM[k] = flagM[k] | liveReg(k, stat);
        d = (it > 20) ? 8'hFF : 8'(r & $urandom());
        psf_host_model_inst.wr(OFS_FAULT_MASK + 8'(k), d);
        maskM[k] = ((k == 0) ? (d | RESERVED_MASK_BITS) : d) & mBits[k];
        d = 8'($urandom() | $urandom());
        psf_host_model_inst.wr(OFS_FAULT_FLAG + 8'(k), d);
        flagM[k] = (flagM[k] & d) | liveReg(k, stat);
      end
      repeat (8) @(posedge clk);
      expIntr = 1'b0;
      for (k = 0; k < 4; k++) begin
        lv = liveReg(k, stat);
        psf_host_model_inst.rd(OFS_FAULT_LIVE + 8'(k), d);
        `CHK(d, lv)
        psf_host_model_inst.rd(OFS_FAULT_FLAG + 8'(k), d);
        `CHK(d, flagM[k])
        psf_host_model_inst.rd(OFS_FAULT_MASK + 8'(k), d);
        `CHK(d, maskM[k])
        expIntr = expIntr | (|(flagM[k] & ~maskM[k]));
      end
      `CHK(intrReq, expIntr)
    end
    finish_test;
  end
endmodule
